// ===== hdl/rsm_consts.svh
`ifndef RSM_CONSTS_SVH
`define RSM_CONSTS_SVH
// Register byte offsets
`define RSM_A_DES 12'h000
`define RSM_A_FES 12'h004
`define RSM_A_FEAR 12'h008
`define RSM_A_FESS 12'h00c
`define RSM_A_FBRE 12'h010
`define RSM_A_FRE 12'h014
`define RSM_A_MCTL 12'h018
`define RSM_A_MSTAT 12'h01c
`define RSM_A_PMASK 12'h020
`define RSM_A_ISTAT 12'h024
`define RSM_A_ICLR 12'h028
`define RSM_A_IEN 12'h02c
// Destructive status layout
`define RSM_DES_W 4
`define RSM_DES_POR 0
`define RSM_DES_CORE_LV 1
`define RSM_DES_SUPPLY_LV 2
`define RSM_DES_EXT 3
`define RSM_DES_RST 4'h1
// Mode control fields
`define RSM_MCTL_TGT_LSB 0
`define RSM_MCTL_SWRST 8
// Mode status fields
`define RSM_MST_MODE_LSB 0
`define RSM_MST_PH_LSB 2
`define RSM_MST_STALL 4
`define RSM_MST_REQ_STOP 5
`define RSM_MST_REQ_EXIT 6
`define RSM_MST_SAFE_LIVE 7
// Interrupt status layout
`define RSM_IRQ_W 3
`define RSM_IRQ_ALT 0
`define RSM_IRQ_STALL 1
`define RSM_IRQ_SAFE 2
// Reset phase lengths in cycles
`define RSM_PH1_CYC 16
`define RSM_PH2_CYC 8
`define RSM_PH3_CYC 8
// Own-drive history before the pad is trusted
`define RSM_OE_HIST 3
`endif

// ===== hdl/rsm_pkg.sv
`default_nettype none
package rsm_pkg;
    typedef enum logic [1:0] {
        RSM_RUN = 2'b00,
        RSM_STOP = 2'b01,
        RSM_SAFE = 2'b10
    } rsm_mode_t;
    typedef enum logic [1:0] {
        RSM_PH_IDLE = 2'b00,
        RSM_PH_ONE = 2'b01,
        RSM_PH_TWO = 2'b10,
        RSM_PH_THREE = 2'b11
    } rsm_phase_t;
endpackage
`default_nettype wire

// ===== hdl/rsm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module rsm_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    // Two-stage capture; only the second stage is read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= INIT;
            q <= INIT;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/rsm_reset_seq.sv
`timescale 1ns/10ps
`default_nettype none
module rsm_reset_seq #(
    parameter int PH1 = 16,
    parameter int PH2 = 8,
    parameter int PH3 = 8,
    parameter int CW = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic start,
    input wire logic short_sel,
    input wire logic pad_en,
    output rsm_pkg::rsm_phase_t phase,
    output logic busy,
    output logic pad_drive,
    output logic done
);
    import rsm_pkg::*;
    logic [CW-1:0] cnt_r;
    assign busy = (phase != RSM_PH_IDLE);
    assign done = (phase == RSM_PH_THREE) && (cnt_r == '0);
    // Phase walk; short sequences skip straight to phase three
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase <= RSM_PH_IDLE;
            cnt_r <= '0;
        end else if (ce) begin
            if (start && !busy) begin
                phase <= short_sel ? RSM_PH_THREE : RSM_PH_ONE;
                cnt_r <= short_sel ? CW'(PH3 - 1) : CW'(PH1 - 1);
            end else if (busy && cnt_r != '0) begin
                cnt_r <= cnt_r - CW'(1);
            end else if (busy) begin
                unique case (phase)
                    RSM_PH_ONE: begin
                        phase <= RSM_PH_TWO;
                        cnt_r <= CW'(PH2 - 1);
                    end
                    RSM_PH_TWO: begin
                        phase <= RSM_PH_THREE;
                        cnt_r <= CW'(PH3 - 1);
                    end
                    default: phase <= RSM_PH_IDLE;
                endcase
            end
        end
    end
    // Pad held for the whole sequence, short or long
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pad_drive <= 1'b0;
        end else if (ce) begin
            if (start && !busy) begin
                pad_drive <= pad_en;
            end else if (done) begin
                pad_drive <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== hdl/rsm_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsm_consts.svh"
// Function
// - Safe request in deep stop enters safe mode at once, whatever the clock config.
// - Alternate request bit routes each functional event not enabled for reset to safe mode or interrupt.
// - Power-up leaves the power-on flag set.
// - Flag clear takes two cycles; a reset in between may leave it set.
// - Per source short-select and pad-enable bits; both honoured together.
// - Short sequence starts at phase three, long at phase one.
// - Safe exit blocked while the live safe condition persists.
// - Deep-stop entry stalls while a disabled peripheral has an interrupt pending.
module rsm_top #(
    parameter int NF = 8,
    parameter int NP = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NF-1:0] func_evt_pin,
    input wire logic por_pin,
    input wire logic core_lv_pin,
    input wire logic supply_lv_pin,
    input wire logic wakeup_pin,
    input wire logic [NP-1:0] periph_irq,
    input wire logic ext_reset_i,
    output logic ext_reset_o,
    output logic ext_reset_oe,
    output rsm_pkg::rsm_mode_t mode_o,
    output rsm_pkg::rsm_phase_t reset_phase_o,
    output logic func_reset_o,
    output logic irq
);
    import rsm_pkg::*;

    logic [NF-1:0] live_s, live_d_r, evt_rise, fes_set;
    logic [NF-1:0] fes_r, fear_r, fess_r, fbre_r, fre_r, fes_clr1_r, fes_clr2_r, fes_wmask;
    logic [`RSM_DES_W-1:0] des_r, des_set, des_clr1_r, des_clr2_r;
    logic [NP-1:0] pmask_r;
    logic [`RSM_IRQ_W-1:0] istat_r, ien_r, irq_set;
    logic [31:0] rdata_nxt, prdata_r;
    logic [2:0] lv_s, lv_d_r;
    logic [`RSM_OE_HIST-1:0] oe_hist_r;
    logic wake_s, ext_s, setup, wr, pslverr_r, boot_r;
    logic req_stop_r, req_exit_r, stall, safe_live, safe_flag, safe_hold;
    logic seq_start, seq_short, seq_pad, seq_busy, seq_pad_drv, seq_done, ext_seen, swrst_wr;
    logic [NF-1:0] rst_evt;
    rsm_mode_t mode_r, mode_nxt;

    // Address known to the register map
    function automatic logic addr_ok(input logic [11:0] a);
        unique case (a)
            `RSM_A_DES, `RSM_A_FES, `RSM_A_FEAR, `RSM_A_FESS, `RSM_A_FBRE, `RSM_A_FRE,
            `RSM_A_MCTL, `RSM_A_MSTAT, `RSM_A_PMASK, `RSM_A_ISTAT, `RSM_A_ICLR,
            `RSM_A_IEN: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction

    // Pins cross into pclk through two flops
    rsm_sync #(.W(NF), .INIT('0)) u_sync_evt (
        .clk(pclk), .rstn(presetn), .ce(ce), .d(func_evt_pin), .q(live_s)
    );
    rsm_sync #(.W(5), .INIT(5'h10)) u_sync_misc (
        .clk(pclk), .rstn(presetn), .ce(ce),
        .d({ext_reset_i, wakeup_pin, supply_lv_pin, core_lv_pin, por_pin}),
        .q({ext_s, wake_s, lv_s})
    );

    rsm_reset_seq #(.PH1(`RSM_PH1_CYC), .PH2(`RSM_PH2_CYC), .PH3(`RSM_PH3_CYC)) u_seq (
        .clk(pclk), .rstn(presetn), .ce(ce), .start(seq_start), .short_sel(seq_short),
        .pad_en(seq_pad), .phase(reset_phase_o), .busy(seq_busy), .pad_drive(seq_pad_drv),
        .done(seq_done)
    );

    // APB: zero wait states, read data captured in setup
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    always_comb begin
        rdata_nxt = 32'h0;
        unique case (paddr)
            `RSM_A_DES: rdata_nxt[`RSM_DES_W-1:0] = des_r;
            `RSM_A_FES: rdata_nxt[NF-1:0] = fes_r;
            `RSM_A_FEAR: rdata_nxt[NF-1:0] = fear_r;
            `RSM_A_FESS: rdata_nxt[NF-1:0] = fess_r;
            `RSM_A_FBRE: rdata_nxt[NF-1:0] = fbre_r;
            `RSM_A_FRE: rdata_nxt[NF-1:0] = fre_r;
            `RSM_A_MSTAT: begin
                rdata_nxt[`RSM_MST_MODE_LSB +: 2] = mode_r;
                rdata_nxt[`RSM_MST_PH_LSB +: 2] = reset_phase_o;
                rdata_nxt[`RSM_MST_STALL] = stall;
                rdata_nxt[`RSM_MST_REQ_STOP] = req_stop_r;
                rdata_nxt[`RSM_MST_REQ_EXIT] = req_exit_r;
                rdata_nxt[`RSM_MST_SAFE_LIVE] = safe_hold;
            end
            `RSM_A_PMASK: rdata_nxt[NP-1:0] = pmask_r;
            `RSM_A_ISTAT: rdata_nxt[`RSM_IRQ_W-1:0] = istat_r;
            `RSM_A_IEN: rdata_nxt[`RSM_IRQ_W-1:0] = ien_r;
            default: rdata_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end else if (ce && setup) begin
            prdata_r <= pwrite ? 32'h0 : rdata_nxt;
            pslverr_r <= !addr_ok(paddr);
        end
    end

    // Software-written configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fear_r <= '0;
            fess_r <= '0;
            fbre_r <= '0;
            fre_r <= '0;
            pmask_r <= '0;
            ien_r <= '0;
        end else if (ce && wr) begin
            if (paddr == `RSM_A_FEAR) fear_r <= pwdata[NF-1:0];
            if (paddr == `RSM_A_FESS) fess_r <= pwdata[NF-1:0];
            if (paddr == `RSM_A_FBRE) fbre_r <= pwdata[NF-1:0];
            if (paddr == `RSM_A_FRE) fre_r <= pwdata[NF-1:0];
            if (paddr == `RSM_A_PMASK) pmask_r <= pwdata[NP-1:0];
            if (paddr == `RSM_A_IEN) ien_r <= pwdata[`RSM_IRQ_W-1:0];
        end
    end

    // Event edges and their routing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_d_r <= '0;
            lv_d_r <= '0;
        end else if (ce) begin
            live_d_r <= live_s;
            lv_d_r <= lv_s;
        end
    end
    assign evt_rise = live_s & ~live_d_r;
    assign fes_set = evt_rise;
    assign rst_evt = evt_rise & fre_r;
    assign safe_live = |(live_s & ~fear_r & ~fre_r);
    assign safe_flag = |(fes_r & ~fear_r & ~fre_r);
    assign safe_hold = safe_live || safe_flag;
    assign fes_wmask = (wr && paddr == `RSM_A_FES) ? pwdata[NF-1:0] : '0;

    // External pad sensed only once our own drive has settled
    assign ext_seen = !ext_s && !seq_busy && (oe_hist_r == '0) && !seq_pad_drv;
    assign swrst_wr = wr && (paddr == `RSM_A_MCTL) && pwdata[`RSM_MCTL_SWRST];
    assign seq_start = !seq_busy && ((|rst_evt) || swrst_wr || ext_seen);
    // Short only if every triggering source asks for it
    assign seq_short = (|rst_evt) && ((rst_evt & ~fess_r) == '0) && !swrst_wr && !ext_seen;
    assign seq_pad = |(rst_evt & fbre_r);
    assign ext_reset_o = 1'b0;
    assign ext_reset_oe = seq_pad_drv;
    assign func_reset_o = seq_busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_hist_r <= '0;
        end else if (ce) begin
            oe_hist_r <= {oe_hist_r[`RSM_OE_HIST-2:0], seq_pad_drv};
        end
    end

    // Clear requests pass two stages; a reset sequence aborts them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fes_clr1_r <= '0;
            fes_clr2_r <= '0;
            des_clr1_r <= '0;
            des_clr2_r <= '0;
        end else if (ce) begin
            fes_clr1_r <= seq_start ? '0 : fes_wmask;
            fes_clr2_r <= seq_start ? '0 : fes_clr1_r;
            des_clr1_r <= (!seq_start && wr && paddr == `RSM_A_DES) ? pwdata[`RSM_DES_W-1:0] : '0;
            des_clr2_r <= seq_start ? '0 : des_clr1_r;
        end
    end

    // Status flags; a new event wins over a clear
    assign des_set = {ext_seen, lv_s[2] & ~lv_d_r[2], lv_s[1] & ~lv_d_r[1], lv_s[0] & ~lv_d_r[0]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fes_r <= '0;
            des_r <= `RSM_DES_RST;
        end else if (ce) begin
            fes_r <= (fes_r & ~fes_clr2_r) | fes_set;
            des_r <= (des_r & ~des_clr2_r) | des_set;
        end
    end

    // Pending mode requests from software
    assign stall = req_stop_r && (|(periph_irq & pmask_r));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_stop_r <= 1'b0;
            req_exit_r <= 1'b0;
        end else if (ce) begin
            if (seq_start) begin
                req_stop_r <= 1'b0;
                req_exit_r <= 1'b0;
            end else if (wr && paddr == `RSM_A_MCTL) begin
                req_stop_r <= (pwdata[`RSM_MCTL_TGT_LSB +: 2] == RSM_STOP) && (mode_r == RSM_RUN);
                req_exit_r <= (pwdata[`RSM_MCTL_TGT_LSB +: 2] == RSM_RUN) && (mode_r == RSM_SAFE);
            end else begin
                if (mode_r != RSM_RUN || mode_nxt == RSM_STOP) req_stop_r <= 1'b0;
                if (mode_r != RSM_SAFE || mode_nxt == RSM_RUN) req_exit_r <= 1'b0;
            end
        end
    end

    // Mode state machine
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            RSM_RUN: begin
                if (safe_hold) mode_nxt = RSM_SAFE;
                else if (req_stop_r && !stall) mode_nxt = RSM_STOP;
            end
            // No dependence on deep-stop clock settings
            RSM_STOP: begin
                if (safe_hold) mode_nxt = RSM_SAFE;
                else if (wake_s) mode_nxt = RSM_RUN;
            end
            RSM_SAFE: begin
                if (req_exit_r && !safe_hold) mode_nxt = RSM_RUN;
            end
            default: mode_nxt = RSM_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= RSM_RUN;
        end else if (ce) begin
            mode_r <= seq_start ? RSM_RUN : mode_nxt;
        end
    end
    assign mode_o = mode_r;

    // Sticky interrupt status, write-one clear, enable gate
    assign irq_set[`RSM_IRQ_ALT] = |(evt_rise & fear_r & ~fre_r);
    assign irq_set[`RSM_IRQ_STALL] = stall;
    assign irq_set[`RSM_IRQ_SAFE] = (mode_nxt == RSM_SAFE) && (mode_r != RSM_SAFE) && !seq_start;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_r <= '0;
        end else if (ce) begin
            if (wr && paddr == `RSM_A_ICLR) istat_r <= (istat_r & ~pwdata[`RSM_IRQ_W-1:0]) | irq_set;
            else istat_r <= istat_r | irq_set;
        end
    end
    assign irq = |(istat_r & ien_r);

    // Marks the first enabled cycle after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_r <= 1'b0;
        end else if (ce) begin
            boot_r <= 1'b1;
        end
    end

    property p_stop_to_safe;
        @(posedge pclk) disable iff (!presetn || !ce)
        mode_r == RSM_STOP && safe_hold && !seq_start |=> mode_r == RSM_SAFE;
    endproperty
    a_stop_to_safe: assert property (p_stop_to_safe) else $error("deep stop did not enter safe");

    property p_alt_irq;
        @(posedge pclk) disable iff (!presetn || !ce)
        |(evt_rise & fear_r & ~fre_r) |=> istat_r[`RSM_IRQ_ALT] &&
            (mode_r != RSM_SAFE || $past(mode_r) == RSM_SAFE || $past(safe_hold));
    endproperty
    a_alt_irq: assert property (p_alt_irq) else $error("alternate event not raised as interrupt");

    property p_por_flag;
        @(posedge pclk) disable iff (!presetn || !ce)
        !boot_r |-> des_r[`RSM_DES_POR];
    endproperty
    a_por_flag: assert property (p_por_flag) else $error("power-on flag missing after reset");

    property p_clr_two;
        @(posedge pclk) disable iff (!presetn || !ce)
        fes_wmask != '0 && !seq_start ##1 !seq_start ##1 fes_set == '0 |=> (fes_r & $past(fes_wmask, 3)) == '0;
    endproperty
    a_clr_two: assert property (p_clr_two) else $error("flag not cleared two cycles after write");

    property p_clr_not_early;
        @(posedge pclk) disable iff (!presetn || !ce)
        fes_wmask != '0 && (fes_clr2_r & fes_wmask) == '0 && (fes_r & fes_wmask) == fes_wmask |=>
            (fes_r & $past(fes_wmask)) == $past(fes_wmask);
    endproperty
    a_clr_not_early: assert property (p_clr_not_early) else $error("flag cleared too early");

    property p_pad;
        @(posedge pclk) disable iff (!presetn || !ce)
        seq_start && seq_pad |=> ext_reset_oe [*4];
    endproperty
    a_pad: assert property (p_pad) else $error("external reset not driven");

    property p_short_three;
        @(posedge pclk) disable iff (!presetn || !ce)
        seq_start && seq_short |=> reset_phase_o == RSM_PH_THREE;
    endproperty
    a_short_three: assert property (p_short_three) else $error("short sequence not at phase three");

    property p_long_one;
        @(posedge pclk) disable iff (!presetn || !ce)
        seq_start && !seq_short |=> reset_phase_o == RSM_PH_ONE ##1 reset_phase_o == RSM_PH_ONE;
    endproperty
    a_long_one: assert property (p_long_one) else $error("long sequence not at phase one");

    property p_safe_held;
        @(posedge pclk) disable iff (!presetn || !ce)
        mode_r == RSM_SAFE && safe_live && !seq_start |=> mode_r == RSM_SAFE;
    endproperty
    a_safe_held: assert property (p_safe_held) else $error("safe exit with live condition");

    property p_stall;
        @(posedge pclk) disable iff (!presetn || !ce)
        mode_r == RSM_RUN && stall && !safe_hold && !seq_start |=> mode_r == RSM_RUN;
    endproperty
    a_stall: assert property (p_stall) else $error("deep stop entered with pending interrupt");

    c_stop_safe: cover property (@(posedge pclk) mode_r == RSM_STOP ##1 mode_r == RSM_SAFE);
    c_safe_exit: cover property (@(posedge pclk) mode_r == RSM_SAFE ##1 mode_r == RSM_RUN);
    c_short_pad: cover property (@(posedge pclk) seq_start && seq_short && seq_pad);
    c_stall: cover property (@(posedge pclk) stall ##1 stall ##1 !stall);
endmodule
`default_nettype wire

// ===== verif/test_reset_event_safe_mode_logic.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsm_consts.svh"
// One comparison, counted, reported at once on mismatch
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); n_errors++; end end
module test_reset_event_safe_mode_logic;
import rsm_pkg::*;
logic pclk = 1'b0;
logic presetn = 1'b0;
logic ce = 1'b1;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = '0;
logic [31:0] pwdata = '0;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic [7:0] evt = '0;
logic [7:0] pirq = '0;
logic wake = 1'b0;
logic pad_o;
logic pad_oe;
logic pad;
rsm_mode_t mode_o;
rsm_phase_t phase_o;
logic func_reset_o;
logic irq;
logic [31:0] q;
int n_errors = 0;
int n_tests = 0;
// Open-drain reset pad with pull-up, fed back to the sense input
assign pad = pad_oe ? pad_o : 1'b1;
rsm_top rsm_top_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .func_evt_pin(evt), .por_pin(1'b0),
    .core_lv_pin(1'b0), .supply_lv_pin(1'b0), .wakeup_pin(wake),
    .periph_irq(pirq), .ext_reset_i(pad), .ext_reset_o(pad_o),
    .ext_reset_oe(pad_oe), .mode_o(mode_o), .reset_phase_o(phase_o),
    .func_reset_o(func_reset_o), .irq(irq)
);
// 200 MHz clock
initial begin
    forever #2.5 pclk = ~pclk;
end
task automatic tick(input int n);
    repeat (n) @(posedge pclk);
endtask
// APB transfer; holds the request until pready, then one idle edge
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
        @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
endtask
task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, q);
endtask
task automatic t_reset;
    rd(`RSM_A_DES);
    `CHK("des", {28'h0000000, `RSM_DES_RST}, q);
    rd(`RSM_A_MSTAT);
    `CHK("mstat", 32'h0, q);
    `CHK("irq", 1'b0, irq);
    rd(12'h030);
    `CHK("unmapped err", 1'b1, pslverr);
    `CHK("pready", 1'b1, pready);
    `CHK("unmapped data", 32'h0, q);
endtask
// Event routed to interrupt; mask, clear and flag clear
task automatic t_route;
    wr(`RSM_A_FEAR, 32'h1);
    wr(`RSM_A_IEN, 32'h1);
    evt[0] <= 1'b1;
    tick(8);
    `CHK("alt mode", RSM_RUN, mode_o);
    `CHK("alt irq", 1'b1, irq);
    wr(`RSM_A_IEN, 32'h0);
    `CHK("masked irq", 1'b0, irq);
    wr(`RSM_A_IEN, 32'h1);
    wr(`RSM_A_ICLR, 32'h1);
    rd(`RSM_A_ISTAT);
    `CHK("istat clr", 1'b0, q[`RSM_IRQ_ALT]);
    `CHK("irq clr", 1'b0, irq);
    evt[0] <= 1'b0;
    rd(`RSM_A_FES);
    `CHK("fes set", 1'b1, q[0]);
    wr(`RSM_A_FES, 32'h1);
    // Clear lands two edges after the write; a read set up sooner sees the old flag
    tick(1);
    rd(`RSM_A_FES);
    `CHK("fes clr", 1'b0, q[0]);
endtask
// Safe entry, exit refused while the live condition stays
task automatic t_safe;
    evt[1] <= 1'b1;
    tick(8);
    `CHK("safe mode", RSM_SAFE, mode_o);
    rd(`RSM_A_MSTAT);
    `CHK("safe hold", 1'b1, q[`RSM_MST_SAFE_LIVE]);
    wr(`RSM_A_FES, 32'h2);
    wr(`RSM_A_MCTL, 32'h0);
    tick(6);
    `CHK("exit refused", RSM_SAFE, mode_o);
    evt[1] <= 1'b0;
    tick(6);
    wr(`RSM_A_MCTL, 32'h0);
    tick(4);
    `CHK("exit done", RSM_RUN, mode_o);
    rd(`RSM_A_ISTAT);
    `CHK("safe istat", 1'b1, q[`RSM_IRQ_SAFE]);
    wr(`RSM_A_ICLR, 32'h4);
endtask
// Stall on pending peripheral, then safe entry straight from deep stop
task automatic t_stop;
    wr(`RSM_A_PMASK, 32'h1);
    pirq <= 8'h01;
    wr(`RSM_A_MCTL, 32'h1);
    tick(6);
    `CHK("stall mode", RSM_RUN, mode_o);
    rd(`RSM_A_MSTAT);
    `CHK("stall bits", 2'b11, q[`RSM_MST_REQ_STOP:`RSM_MST_STALL]);
    pirq <= 8'h00;
    tick(4);
    `CHK("stop mode", RSM_STOP, mode_o);
    evt[2] <= 1'b1;
    tick(8);
    `CHK("stop to safe", RSM_SAFE, mode_o);
    evt[2] <= 1'b0;
    wr(`RSM_A_FES, 32'h4);
    tick(6);
    wr(`RSM_A_MCTL, 32'h0);
    tick(4);
    `CHK("run again", RSM_RUN, mode_o);
    wr(`RSM_A_MCTL, 32'h1);
    tick(4);
    `CHK("stop again", RSM_STOP, mode_o);
    wake <= 1'b1;
    tick(6);
    `CHK("wake", RSM_RUN, mode_o);
    wake <= 1'b0;
endtask
// Functional reset from source s: first phase, pad drive, length
task automatic seq(input int s, input rsm_phase_t ph, input logic pd, input int len);
    int k;
    int n;
    k = 0;
    n = 0;
    evt[s] <= 1'b1;
    do begin
        @(negedge pclk);
        k++;
    end while (func_reset_o !== 1'b1 && k < 20);
    `CHK("first phase", ph, phase_o);
    `CHK("pad drive", pd, pad_oe);
    `CHK("pad level", 1'b0, pad_o);
    while (func_reset_o === 1'b1 && n < 100) begin
        n++;
        @(negedge pclk);
    end
    `CHK("seq length", len, n);
    @(posedge pclk);
    evt[s] <= 1'b0;
    wr(`RSM_A_FES, 32'h1 << s);
endtask
task automatic t_seq;
    wr(`RSM_A_FRE, 32'h38);
    wr(`RSM_A_FESS, 32'h28);
    wr(`RSM_A_FBRE, 32'h08);
    seq(3, RSM_PH_THREE, 1'b1, `RSM_PH3_CYC);
    seq(4, RSM_PH_ONE, 1'b0, `RSM_PH1_CYC + `RSM_PH2_CYC + `RSM_PH3_CYC);
    seq(5, RSM_PH_THREE, 1'b0, `RSM_PH3_CYC);
    // Confirm the last clear before the software reset, else it may abort it
    tick(1);
    rd(`RSM_A_FES);
    `CHK("fes readback", 32'h0, q);
    wr(`RSM_A_MCTL, 32'h100);
    `CHK("swrst phase", RSM_PH_ONE, phase_o);
    `CHK("swrst pad", 1'b0, pad_oe);
    tick(`RSM_PH1_CYC + `RSM_PH2_CYC + `RSM_PH3_CYC);
    `CHK("swrst end", RSM_PH_IDLE, phase_o);
endtask
// Clock enable low freezes all state, synchronisers included
task automatic t_freeze;
    ce <= 1'b0;
    evt[1] <= 1'b1;
    tick(6);
    `CHK("frozen mode", RSM_RUN, mode_o);
    evt[1] <= 1'b0;
    tick(2);
    ce <= 1'b1;
    tick(6);
    `CHK("thawed mode", RSM_RUN, mode_o);
    rd(`RSM_A_FES);
    `CHK("frozen fes", 32'h0, q);
endtask
task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask
// Main sequence after 8 cycles of reset
initial begin
    tick(8);
    presetn <= 1'b1;
    tick(1);
    t_reset;
    t_route;
    t_safe;
    t_stop;
    t_seq;
    t_freeze;
    close_out;
end
// Watchdog, far beyond the few hundred cycles the tests need
initial begin
    tick(20000);
    n_errors++;
    close_out;
end
endmodule
`default_nettype wire
